// [design/pin_output_map.vh]
// Purpose: Register offsets, field positions and reset values for the pin output set alias
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by bare name from the register block design file
`ifndef PIN_OUTPUT_MAP_VH
`define PIN_OUTPUT_MAP_VH

`define PIN_OUTPUT_SET_ALIAS_OFFSET   8'h1c
`define PIN_OUTPUT_LATCH_OFFSET       8'h40
`define PIN_FUNCTION_SELECT_OFFSET    8'h44
`define PIN_DIRECTION_OFFSET          8'h48
`define PIN_LEVEL_OFFSET              8'h4c
`define APB_ADDR_WIDTH                8
`define PIN_COUNT                     32
`define PIN_CTRL_MSB                  31
`define PIN_CTRL_LSB                  25
`define PIN_RSVD_MSB                  24
`define PIN_RSVD_LSB                  16
`define PIN_DATA_MSB                  15
`define PIN_DATA_LSB                  0
`define PIN_IMPLEMENTED_MASK          32'hfe00ffff
`define PIN_OUTPUT_LATCH_RESET        32'h00000000
`define PIN_FUNCTION_SELECT_RESET     32'h00000000
`define PIN_DIRECTION_RESET           32'h00000000
`define PIN_READ_ZERO                 32'h00000000

`endif

// [design/pin_drive_slice.v]
// Purpose: Per-pin output latch bit and pin driver
// Assumes: Set and write strobes are one-cycle pulses on clk_i
// Notes:   Direct write wins over set when both arrive together
`timescale 1ns/10ps
`default_nettype none

module pin_drive_slice
(
    input  wire clk_i,
    input  wire reset_n_i,
    input  wire set_i,
    input  wire wr_i,
    input  wire wr_data_i,
    input  wire func_gpio_i,
    input  wire dir_out_i,
    input  wire periph_data_i,
    input  wire periph_oe_i,
    output reg  latch_o,
    output wire pin_o,
    output wire pin_oe_o
);

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            latch_o <= 1'b0;
        else if (wr_i)
            latch_o <= wr_data_i;
        else if (set_i)
            latch_o <= 1'b1; // R2
    end

    // Latch value is held while the pin serves its peripheral
    assign pin_o    = func_gpio_i ? latch_o : periph_data_i; // R3 R9
    assign pin_oe_o = func_gpio_i ? dir_out_i : periph_oe_i; // R3 R9

endmodule // pin_drive_slice

`default_nettype wire

// [design/pin_output_set.v]
// Purpose: APB register block with the write-only set alias onto the pin output latch
// Assumes: Single clock clk_i at 50 MHz, APB3 slave, zero wait states
// Notes:   Function select, direction and latch registers sit at offsets chosen here
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pin_output_map.vh"

// Overview of operation
// R1 - The set alias has no storage and only writes onto the existing output latch.
// R2 - Each bit written as one to the set alias sets the matching output latch bit.
// R3 - A set latch bit drives its pin high when the pin is in GPIO mode and an output.
// R4 - Bits written as zero change nothing, so other latch bits and pins keep their values.
// R5 - Alias bits 31 to 25 serve the frame sync, clock and mute pins in documented order.
// R6 - Alias bits 15 to 0 map one-to-one onto the sixteen serializer data pins.
// R7 - Reserved bits 24 to 16 read as zero and writes to them affect no state.
// R8 - Software writes only zeros to reserved positions.
// R9 - A latch bit set while its pin is not a GPIO output holds and applies once selected.
module pin_output_set
#(
    parameter [31:0] IMPL_MASK = `PIN_IMPLEMENTED_MASK
)
(
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [31:0] pin_level_i,
    input  wire [31:0] periph_data_i,
    input  wire [31:0] periph_oe_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    output wire [31:0] pin_output_latch_o,
    output wire [31:0] pin_o,
    output wire [31:0] pin_oe_o
);

    // Pin groups of the alias word
    localparam CTRL_WIDTH = `PIN_CTRL_MSB - `PIN_CTRL_LSB + 1;
    localparam RSVD_WIDTH = `PIN_RSVD_MSB - `PIN_RSVD_LSB + 1;
    localparam DATA_WIDTH = `PIN_DATA_MSB - `PIN_DATA_LSB + 1;

    // Mode and read state; the set alias itself owns no flop
    reg  [31:0]           pin_function_select_q;
    reg  [31:0]           pin_function_select_d;
    reg  [31:0]           pin_direction_q;
    reg  [31:0]           pin_direction_d;
    reg  [31:0]           prdata_d;
    reg  [31:0]           rd_d;

    // Bus decode
    reg                   hit_set;
    reg                   hit_latch;
    reg                   hit_func;
    reg                   hit_dir;
    reg                   hit_level;

    wire                  setup_phase;
    wire                  access_phase;
    wire                  wr_access;
    wire                  rd_access;
    wire                  hit_any;
    wire                  unmapped;
    wire                  wr_set;
    wire                  wr_latch;
    wire                  wr_func;
    wire                  wr_dir;

    // Data paths towards the slices and the read mux
    wire [31:0]           wr_data_masked;
    wire [31:0]           rd_level;
    wire [CTRL_WIDTH-1:0] set_ctrl;
    wire [DATA_WIDTH-1:0] set_data;
    wire [31:0]           set_vec;
    wire [31:0]           latch_wr_en;

    // Setup has psel alone, access has penable as well
    assign setup_phase  = psel_i & ~penable_i;
    assign access_phase = psel_i & penable_i;
    assign wr_access    = access_phase & pwrite_i;
    assign rd_access    = setup_phase & ~pwrite_i;

    // One register per address; every other address is unmapped
    always @*
    begin
        hit_set   = 1'b0;
        hit_latch = 1'b0;
        hit_func  = 1'b0;
        hit_dir   = 1'b0;
        hit_level = 1'b0;
        case (paddr_i)
            `PIN_OUTPUT_SET_ALIAS_OFFSET: hit_set   = 1'b1;
            `PIN_OUTPUT_LATCH_OFFSET:     hit_latch = 1'b1;
            `PIN_FUNCTION_SELECT_OFFSET:  hit_func  = 1'b1;
            `PIN_DIRECTION_OFFSET:        hit_dir   = 1'b1;
            `PIN_LEVEL_OFFSET:            hit_level = 1'b1;
            default:                      hit_set   = 1'b0;
        endcase
    end

    assign hit_any  = hit_set | hit_latch | hit_func | hit_dir | hit_level;
    assign unmapped = ~hit_any;

    // Write strobes last exactly one access cycle
    assign wr_set   = wr_access & hit_set;
    assign wr_latch = wr_access & hit_latch;
    assign wr_func  = wr_access & hit_func;
    assign wr_dir   = wr_access & hit_dir;

    // Nothing here needs time to answer, so every access ends on its first edge
    assign pready_o  = 1'b1;
    // Unmapped addresses answer with an error so stray pointers show up
    assign pslverr_o = access_phase & unmapped;

    // Unimplemented pins can never be switched to GPIO, made outputs or set
    assign wr_data_masked = pwdata_i & IMPL_MASK;
    assign rd_level       = pin_level_i & IMPL_MASK; // R7

    // A zero in the written word gives no strobe, so that pin keeps its level
    assign set_ctrl = pwdata_i[`PIN_CTRL_MSB:`PIN_CTRL_LSB]       // R5
                    & IMPL_MASK[`PIN_CTRL_MSB:`PIN_CTRL_LSB];
    assign set_data = pwdata_i[`PIN_DATA_MSB:`PIN_DATA_LSB]       // R6
                    & IMPL_MASK[`PIN_DATA_MSB:`PIN_DATA_LSB];
    // Reserved bits 24 to 16 never reach a slice, whatever software writes
    assign set_vec  = wr_set ? {set_ctrl, {RSVD_WIDTH{1'b0}}, set_data} // R1 R4 R7
                             : `PIN_READ_ZERO;

    // A direct latch write reaches implemented pins only
    assign latch_wr_en = wr_latch ? IMPL_MASK : `PIN_READ_ZERO;

    // Next values of the mode registers
    always @*
    begin
        pin_function_select_d = pin_function_select_q;
        if (wr_func)
            pin_function_select_d = wr_data_masked;
    end

    always @*
    begin
        pin_direction_d = pin_direction_q;
        if (wr_dir)
            pin_direction_d = wr_data_masked;
    end

    // Mode flops reset to peripheral drive with every pin an input
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_function_select_q <= `PIN_FUNCTION_SELECT_RESET;
        else
            pin_function_select_q <= pin_function_select_d;
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_direction_q <= `PIN_DIRECTION_RESET;
        else
            pin_direction_q <= pin_direction_d;
    end

    // Slot n drives pin n; reserved slots never set, their latches stay low and their pins follow the peripheral
    // A bit set while its pin serves the peripheral waits here until GPIO mode returns
    genvar n;
    generate
        for (n = 0; n < `PIN_COUNT; n = n + 1)
        begin : g_pin
            pin_drive_slice u_slice
            (
                .clk_i         (clk_i),
                .reset_n_i     (reset_n_i),
                .set_i         (set_vec[n]), // R2 R5 R6
                .wr_i          (latch_wr_en[n]),
                .wr_data_i     (pwdata_i[n]),
                .func_gpio_i   (pin_function_select_q[n]),
                .dir_out_i     (pin_direction_q[n]),
                .periph_data_i (periph_data_i[n]),
                .periph_oe_i   (periph_oe_i[n]),
                .latch_o       (pin_output_latch_o[n]),
                .pin_o         (pin_o[n]),
                .pin_oe_o      (pin_oe_o[n])
            );
        end
    endgenerate

    // The set alias is write-only and reads as zero
    always @*
    begin
        rd_d = `PIN_READ_ZERO;
        case (paddr_i)
            `PIN_OUTPUT_SET_ALIAS_OFFSET: rd_d = `PIN_READ_ZERO; // R1
            `PIN_OUTPUT_LATCH_OFFSET:     rd_d = pin_output_latch_o;
            `PIN_FUNCTION_SELECT_OFFSET:  rd_d = pin_function_select_q;
            `PIN_DIRECTION_OFFSET:        rd_d = pin_direction_q;
            `PIN_LEVEL_OFFSET:            rd_d = rd_level;
            default:                      rd_d = `PIN_READ_ZERO;
        endcase
    end

    // Read data is taken in the setup cycle so it stands through the access phase
    always @*
    begin
        prdata_d = prdata_o;
        if (rd_access)
            prdata_d = rd_d;
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            prdata_o <= `PIN_READ_ZERO;
        else
            prdata_o <= prdata_d;
    end

endmodule // pin_output_set

`default_nettype wire

// [dv/set_alias_chk.sv]
// Purpose: Port assertions for the pin output set alias
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the design from tb_top
`timescale 1ns/10ps
`default_nettype none
module set_alias_chk
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic [31:0] pin_output_latch_o
);
    wire set_wr = psel_i && penable_i && pwrite_i && paddr_i == 8'h1c;
    wire any_wr = psel_i && penable_i && pwrite_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_SET: assert property (set_wr |=> &(pin_output_latch_o | ~$past(pwdata_i) | 32'h01ff0000))
        else $error("set bit missing from latch");
    AST_KEEP: assert property (set_wr |=> ((pin_output_latch_o ^ $past(pin_output_latch_o)) & ~$past(pwdata_i)) == 32'h0)
        else $error("zero bit changed latch");
    AST_RD: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == 8'h1c |=> prdata_o == 32'h0)
        else $error("set alias read not zero");
    AST_RSV: assert property ((pin_output_latch_o & 32'h01ff0000) == 32'h0)
        else $error("reserved latch bit set");
    AST_HI: assert property (set_wr && pwdata_i[31:25] == 7'h7f |=> pin_output_latch_o[31:25] == 7'h7f)
        else $error("upper pins not set");
    AST_LO: assert property (set_wr && pwdata_i[15:0] == 16'hffff |=> pin_output_latch_o[15:0] == 16'hffff)
        else $error("data pins not set");
    AST_HOLD: assert property (!any_wr |=> $stable(pin_output_latch_o))
        else $error("latch moved without a write");
    AST_NOP: assert property (set_wr && pwdata_i == 32'h0 |=> $stable(pin_output_latch_o))
        else $error("zero write changed latch");
    cover property (set_wr);
    cover property (set_wr && pwdata_i[24:16] != 9'h0);
    cover property (psel_i && !penable_i && !pwrite_i && paddr_i == 8'h1c);
endmodule // set_alias_chk
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the pin output set alias
// Assumes: The master waits on pready; peripheral drive and pin levels come from the bench
// Notes:   Reserved bits are written on purpose to prove they are ignored
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
    logic        clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, pin_level_i = 32'h0, periph_data_i = 32'h0, periph_oe_i = 32'h0;
    wire  [31:0] prdata_o, pin_output_latch_o, pin_o, pin_oe_o;
    wire         pready_o, pslverr_o;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch = 0, checks = 0;
    always #10 clk_i = ~clk_i;
    pin_output_set i_dut
    (
        .clk_i              (clk_i),
        .reset_n_i          (reset_n_i),
        .psel_i             (psel_i),
        .penable_i          (penable_i),
        .pwrite_i           (pwrite_i),
        .paddr_i            (paddr_i),
        .pwdata_i           (pwdata_i),
        .pin_level_i        (pin_level_i),
        .periph_data_i      (periph_data_i),
        .periph_oe_i        (periph_oe_i),
        .prdata_o           (prdata_o),
        .pready_o           (pready_o),
        .pslverr_o          (pslverr_o),
        .pin_output_latch_o (pin_output_latch_o),
        .pin_o              (pin_o),
        .pin_oe_o           (pin_oe_o)
    );
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        n_mismatch += (n == 20);
        if (n == 20)
            report_and_stop;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task t_set;
        xfer(1'b1, 8'h44, 32'hfe00ffff);
        xfer(1'b1, 8'h48, 32'hfe00ffff);
        xfer(1'b1, 8'h1c, 32'h82000001);
        `CHK(pin_output_latch_o, 32'h82000001)
        `CHK(pin_o, 32'h82000001)
        `CHK(pin_oe_o, 32'hfe00ffff)
        `CHK(err, 1'b0)
        xfer(1'b1, 8'h1c, 32'h00000002);
        `CHK(pin_output_latch_o, 32'h82000003)
        xfer(1'b1, 8'h1c, 32'hfe00ffff);
        `CHK(pin_output_latch_o, 32'hfe00ffff)
        `CHK(pin_o, 32'hfe00ffff)
        $display("set test done");
    endtask
    task t_rsv;
        xfer(1'b1, 8'h40, 32'h00000000);
        xfer(1'b1, 8'h1c, 32'h01ff0004);
        `CHK(pin_output_latch_o, 32'h00000004)
        xfer(1'b1, 8'h1c, 32'h00000000);
        xfer(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h00000004)
        xfer(1'b0, 8'h1c, 32'h0);
        `CHK(rd, 32'h00000000)
        @(posedge clk_i);
        pin_level_i <= 32'hffffffff;
        xfer(1'b0, 8'h4c, 32'h0);
        `CHK(rd, 32'hfe00ffff)
        $display("reserved test done");
    endtask
    task t_hold;
        @(posedge clk_i);
        periph_data_i <= 32'h0000a5a5;
        periph_oe_i <= 32'h00005a5a;
        xfer(1'b1, 8'h44, 32'h00000000);
        xfer(1'b1, 8'h1c, 32'h00000010);
        xfer(1'b1, 8'h80, 32'hffffffff);
        `CHK(err, 1'b1)
        `CHK(pin_output_latch_o, 32'h00000014)
        `CHK(pin_o, 32'h0000a5a5)
        `CHK(pin_oe_o, 32'h00005a5a)
        xfer(1'b1, 8'h44, 32'hfe00ffff);
        `CHK(pin_o, 32'h00000014)
        `CHK(pin_oe_o, 32'hfe00ffff)
        $display("hold test done");
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_set;
        t_rsv;
        t_hold;
        report_and_stop;
    end
endmodule // tb_top
bind pin_output_set set_alias_chk i_chk
(
    .clk_i              (clk_i),
    .reset_n_i          (reset_n_i),
    .psel_i             (psel_i),
    .penable_i          (penable_i),
    .pwrite_i           (pwrite_i),
    .paddr_i            (paddr_i),
    .pwdata_i           (pwdata_i),
    .prdata_o           (prdata_o),
    .pin_output_latch_o (pin_output_latch_o)
);
`default_nettype wire
